// >>> pcw_pkg.sv
package pcw_pkg;
    localparam int unsigned SPACE_NUM = 4;
    localparam int unsigned PART_NUM = 16;
    localparam int unsigned RIS_NUM = 4;
    localparam int unsigned PART_IDX_W = 4;
    localparam int unsigned RIS_IDX_W = 2;
    localparam int unsigned WIDTH_W = 24;
    localparam int unsigned MAP_W = 16;
    localparam int unsigned ADDR_W = 12;

    // security spaces, one feature frame each
    localparam logic [1:0] SPACE_SECURE = 2'h0;
    localparam logic [1:0] SPACE_NONSECURE = 2'h1;
    localparam logic [1:0] SPACE_ROOT = 2'h2;
    localparam logic [1:0] SPACE_REALM = 2'h3;

    // frame offsets
    localparam logic [11:0] OFF_PART_SEL = 12'h100;
    localparam logic [11:0] OFF_WINDOW_WIDTH = 12'h220;
    localparam logic [11:0] OFF_INTID_MAP = 12'h600;
    localparam logic [11:0] OFF_ERR_STATUS = 12'h0F8;
    localparam logic [11:0] OFF_CAPS = 12'h0F0;

    // selector fields
    localparam int unsigned SEL_PARTITION_ID_LSB = 0;
    localparam int unsigned SEL_PARTITION_ID_MSB = 15;
    localparam int unsigned SEL_INTERNAL_BIT = 16;
    localparam int unsigned SEL_RIS_LSB = 24;
    localparam int unsigned SEL_RIS_MSB = 27;
    localparam logic [31:0] SEL_PARTITION_ID_MASK = 32'h0000_FFFF;
    localparam logic [31:0] SEL_INTERNAL_MASK = 32'h0001_0000;
    localparam logic [31:0] SEL_RIS_MASK = 32'h0F00_0000;
    localparam logic [31:0] SEL_RESET = 32'h0000_0000;

    // window width fields
    localparam int unsigned WW_FRAC_LSB = 0;
    localparam int unsigned WW_INT_LSB = 8;
    localparam int unsigned WW_INT_MSB = 23;
    localparam logic [23:0] WW_RESET = 24'h00_0000;
    localparam logic [15:0] MAP_RESET = 16'h0000;

    // error status: code in bits 3..0
    localparam logic [3:0] ERR_NONE = 4'h0;
    localparam logic [3:0] ERR_INTID_RANGE = 4'h1;
    localparam logic [3:0] ERR_UNEXP_INTERNAL = 4'h2;
    localparam logic [3:0] ERR_RESET = 4'h0;
endpackage : pcw_pkg

// >>> pcw_part_sel.sv
`timescale 1ns/1ns
module pcw_part_sel
    import pcw_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // write from this space's frame
    input wire logic wr_en,
    input wire logic [31:0] wdata,
    // capability gates
    input wire logic keep_ris,
    input wire logic keep_internal,
    // held selector
    output logic [31:0] sel_q
);
    logic [31:0] wmask;

    always_comb begin
        wmask = SEL_PARTITION_ID_MASK;
        if (keep_ris) begin
            wmask = wmask | SEL_RIS_MASK;
        end
        if (keep_internal) begin
            wmask = wmask | SEL_INTERNAL_MASK;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sel_q <= SEL_RESET;
        end else if (wr_en) begin
            sel_q <= wdata & wmask;
        end
    end
endmodule : pcw_part_sel

// >>> pcw_winwd_cfg.sv
`timescale 1ns/1ns
module pcw_winwd_cfg
    import pcw_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // capability straps, static while in use
    input wire logic partitioning_feature,
    input wire logic has_bandwidth_partitioning,
    input wire logic window_writable_flag,
    input wire logic has_instance_selection,
    input wire logic extended_id_flag,
    input wire logic has_id_narrowing,
    input wire logic realm_management_support,
    // width set by hardware when not writable
    input wire logic [23:0] hw_window_width,
    // feature frame access
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [1:0] req_space,
    input wire logic [11:0] req_offset,
    input wire logic [31:0] req_wdata,
    // access answer
    output logic rsp_valid,
    output logic [31:0] rsp_rdata,
    // width lookup for the bandwidth regulator
    input wire logic [1:0] lkp_space,
    input wire logic [3:0] lkp_ris,
    input wire logic [15:0] lkp_partition_id,
    output logic [23:0] lkp_width
);
    localparam int unsigned WW_DEPTH = SPACE_NUM * RIS_NUM * PART_NUM;
    localparam int unsigned MAP_DEPTH = SPACE_NUM * PART_NUM;

    function automatic logic [7:0] ww_index(input logic [1:0] space,
                                            input logic [1:0] resource_instance_selector,
                                            input logic [3:0] part);
        ww_index = {space, resource_instance_selector, part};
    endfunction : ww_index

    function automatic logic in_range(input logic [15:0] part, input logic [3:0] resource_instance_selector);
        in_range = (part < 16'(PART_NUM)) && (resource_instance_selector < 4'(RIS_NUM));
    endfunction : in_range

    // selectors, one per space
    logic [31:0] sel_q [SPACE_NUM];
    logic keep_ris;
    logic keep_internal;

    assign keep_ris = extended_id_flag & has_instance_selection;
    assign keep_internal = has_id_narrowing;

    genvar gs;
    generate
        for (gs = 0; gs < SPACE_NUM; gs++) begin : g_sel
            logic sel_wr;
            assign sel_wr = req_valid && req_write && (req_space == 2'(gs))
                            && (req_offset == OFF_PART_SEL);
            pcw_part_sel u_sel (
                .clk_sys(clk_sys),
                .srst(srst),
                .wr_en(sel_wr),
                .wdata(req_wdata),
                .keep_ris(keep_ris),
                .keep_internal(keep_internal),
                .sel_q(sel_q[gs])
            );
        end
    endgenerate

    // decode of the current access
    logic [31:0] cur_sel;
    logic [15:0] cur_part;
    logic [3:0] cur_ris;
    logic cur_internal;
    logic cur_ok;
    logic hit_sel;
    logic hit_ww;
    logic hit_map;
    logic hit_err;
    logic hit_caps;
    logic ww_present;
    logic map_present;
    logic err_unexp;
    logic err_range;
    logic cfg_err;
    logic [7:0] cur_ww_idx;
    logic [5:0] cur_map_idx;

    always_comb begin
        cur_sel = sel_q[req_space];
        cur_part = cur_sel[SEL_PARTITION_ID_MSB:SEL_PARTITION_ID_LSB];
        cur_internal = cur_sel[SEL_INTERNAL_BIT];
        if (has_instance_selection) begin
            cur_ris = cur_sel[SEL_RIS_MSB:SEL_RIS_LSB];
        end else begin
            cur_ris = 4'h0;
        end
    end

    assign cur_ok = in_range(cur_part, cur_ris);
    assign cur_ww_idx = ww_index(req_space, cur_ris[1:0], cur_part[3:0]);
    assign cur_map_idx = {req_space, cur_part[3:0]};

    assign hit_sel = req_valid && (req_offset == OFF_PART_SEL);
    assign hit_ww = req_valid && (req_offset == OFF_WINDOW_WIDTH);
    assign hit_map = req_valid && (req_offset == OFF_INTID_MAP);
    assign hit_err = req_valid && (req_offset == OFF_ERR_STATUS);
    assign hit_caps = req_valid && (req_offset == OFF_CAPS);

    // root and realm frames only carry the width with realm support
    assign ww_present = partitioning_feature && has_bandwidth_partitioning
                        && ((req_space == SPACE_SECURE) || (req_space == SPACE_NONSECURE)
                            || realm_management_support);
    assign map_present = partitioning_feature && has_id_narrowing;

    // flag checks only exist when narrowing is built in
    assign err_unexp = has_id_narrowing && hit_map && map_present
                       && cur_internal;
    assign err_range = has_id_narrowing && hit_ww && ww_present
                       && !cur_internal;
    assign cfg_err = err_unexp || err_range;

    // window width storage, separate per space
    logic [23:0] ww_mem [WW_DEPTH];
    logic ww_wr;

    assign ww_wr = hit_ww && req_write && ww_present && window_writable_flag
                   && !cfg_err && cur_ok;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            for (int i = 0; i < WW_DEPTH; i++) begin
                ww_mem[i] <= WW_RESET;
            end
        end else if (ww_wr) begin
            ww_mem[cur_ww_idx] <= req_wdata[WW_INT_MSB:WW_FRAC_LSB];
        end
    end

    // internal id mapping, indexed by request id with flag clear
    logic [15:0] map_mem [MAP_DEPTH];
    logic map_wr;

    assign map_wr = hit_map && req_write && map_present && !cfg_err
                    && (cur_part < 16'(PART_NUM));

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            for (int i = 0; i < MAP_DEPTH; i++) begin
                map_mem[i] <= MAP_RESET;
            end
        end else if (map_wr) begin
            map_mem[cur_map_idx] <= req_wdata[MAP_W-1:0];
        end
    end

    // error status per space; a new error beats a clearing write
    logic [3:0] err_q [SPACE_NUM];

    generate
        for (gs = 0; gs < SPACE_NUM; gs++) begin : g_err
            logic own;
            assign own = (req_space == 2'(gs));
            always_ff @(posedge clk_sys) begin
                if (srst) begin
                    err_q[gs] <= ERR_RESET;
                end else if (own && err_unexp) begin
                    err_q[gs] <= ERR_UNEXP_INTERNAL;
                end else if (own && err_range) begin
                    err_q[gs] <= ERR_INTID_RANGE;
                end else if (own && hit_err && req_write) begin
                    err_q[gs] <= ERR_NONE;
                end
            end
        end
    endgenerate

    // read path
    logic [31:0] rd_d;
    logic [23:0] ww_view;

    always_comb begin
        if (window_writable_flag) begin
            ww_view = cur_ok ? ww_mem[cur_ww_idx] : WW_RESET;
        end else begin
            ww_view = hw_window_width;
        end
    end

    always_comb begin
        rd_d = 32'h0000_0000;
        if (hit_sel) begin
            rd_d = cur_sel;
        end else if (hit_ww && ww_present && !cfg_err) begin
            rd_d = {8'h00, ww_view};
        end else if (hit_map && map_present && !cfg_err && (cur_part < 16'(PART_NUM))) begin
            rd_d = {16'h0000, map_mem[cur_map_idx]};
        end else if (hit_err) begin
            rd_d = {28'h000_0000, err_q[req_space]};
        end else if (hit_caps) begin
            rd_d = {25'h000_0000, realm_management_support, has_id_narrowing,
                    extended_id_flag, has_instance_selection, window_writable_flag,
                    has_bandwidth_partitioning, partitioning_feature};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rsp_valid <= 1'b0;
        end else begin
            rsp_valid <= req_valid;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            rsp_rdata <= 32'h0000_0000;
        end else if (req_valid) begin
            rsp_rdata <= (req_write) ? 32'h0000_0000 : rd_d;
        end
    end

    // regulator lookup, one cycle
    logic [3:0] lkp_ris_eff;

    assign lkp_ris_eff = has_instance_selection ? lkp_ris : 4'h0;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            lkp_width <= WW_RESET;
        end else if (!window_writable_flag) begin
            lkp_width <= hw_window_width;
        end else if (in_range(lkp_partition_id, lkp_ris_eff)) begin
            lkp_width <= ww_mem[ww_index(lkp_space, lkp_ris_eff[1:0], lkp_partition_id[3:0])];
        end else begin
            lkp_width <= WW_RESET;
        end
    end
endmodule : pcw_winwd_cfg

// >>> pcw_winwd_cfg_assertions.sv
`timescale 1ns/1ns
module pcw_chk
    import pcw_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic srst,
    // straps
    input wire logic partitioning_feature,
    input wire logic has_bandwidth_partitioning,
    input wire logic window_writable_flag,
    input wire logic has_instance_selection,
    input wire logic extended_id_flag,
    input wire logic has_id_narrowing,
    input wire logic realm_management_support,
    input wire logic [23:0] hw_window_width,
    // access
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [11:0] req_offset,
    input wire logic [1:0] req_space,
    input wire logic rsp_valid,
    input wire logic [31:0] rsp_rdata,
    // lookup
    input wire logic [1:0] lkp_space,
    input wire logic [15:0] lkp_partition_id,
    input wire logic [23:0] lkp_width
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);
    logic rd_sel;
    logic rd_ww;
    logic ww_on;
    assign rd_sel = req_valid && !req_write && req_offset == OFF_PART_SEL;
    assign rd_ww = req_valid && !req_write && req_offset == OFF_WINDOW_WIDTH;
    assign ww_on = partitioning_feature && has_bandwidth_partitioning;

    AST_WW_TOP_ZERO: assert property (rd_ww |=> rsp_valid && rsp_rdata[31:24] == 8'h00)
        else $error("width read shows reserved bits");
    AST_SEL_RSVD: assert property (rd_sel |=> rsp_rdata[31:28] == 4'h0 && rsp_rdata[23:17] == 7'h00)
        else $error("selector read shows reserved bits");
    AST_SEL_NO_RIS: assert property (rd_sel && !(extended_id_flag && has_instance_selection)
        |=> rsp_rdata[27:24] == 4'h0)
        else $error("instance field kept without capability");
    AST_SEL_NO_INT: assert property (rd_sel && !has_id_narrowing |=> !rsp_rdata[16])
        else $error("internal flag set without narrowing");
    AST_WW_ABSENT: assert property (rd_ww && !ww_on |=> rsp_rdata == 32'h0000_0000)
        else $error("absent width register reads nonzero");
    AST_WW_NO_REALM: assert property (rd_ww && req_space[1] && !realm_management_support
        |=> rsp_rdata == 32'h0000_0000)
        else $error("root or realm width reachable without support");
    AST_WW_HW: assert property (rd_ww && ww_on && !window_writable_flag && !has_id_narrowing
        && (!req_space[1] || realm_management_support)
        |=> rsp_rdata == {8'h00, $past(hw_window_width)})
        else $error("read-only width differs from hardware value");
    AST_LKP_HW: assert property (ww_on && !window_writable_flag && !lkp_space[1]
        && lkp_partition_id[15:4] == 12'h000 |=> lkp_width == $past(hw_window_width))
        else $error("lookup width differs from hardware value");
endmodule : pcw_chk

bind pcw_winwd_cfg pcw_chk u_chk (.clk_sys, .srst, .partitioning_feature,
    .has_bandwidth_partitioning, .window_writable_flag, .has_instance_selection,
    .extended_id_flag, .has_id_narrowing, .realm_management_support, .hw_window_width,
    .req_valid, .req_write, .req_offset, .req_space, .rsp_valid, .rsp_rdata,
    .lkp_space, .lkp_partition_id, .lkp_width);

// >>> partition_cfg_select_winwidth_tb_top.sv
`timescale 1ns/1ns
module partition_cfg_select_winwidth_tb_top
    import pcw_pkg::*;
;
    localparam logic [31:0] zero = 32'h0000_0000;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic partitioning_feature, has_bandwidth_partitioning, window_writable_flag;
    logic has_instance_selection, extended_id_flag, has_id_narrowing;
    logic realm_management_support, req_valid, req_write, rsp_valid;
    logic [23:0] hw_window_width, lkp_width;
    logic [1:0] req_space, lkp_space;
    logic [11:0] req_offset;
    logic [31:0] req_wdata, rsp_rdata, seed;
    logic [3:0] lkp_ris;
    logic [15:0] lkp_partition_id;
    logic [31:0] wv[4];
    logic [31:0] exp_q[$];
    int failures = 0;
    int compares = 0;

    initial begin
        forever #50 clk_sys = ~clk_sys;
    end

    pcw_winwd_cfg u_dut (.clk_sys, .srst, .partitioning_feature, .has_bandwidth_partitioning,
        .window_writable_flag, .has_instance_selection, .extended_id_flag, .has_id_narrowing,
        .realm_management_support, .hw_window_width, .req_valid, .req_write, .req_space,
        .req_offset, .req_wdata, .rsp_valid, .rsp_rdata, .lkp_space, .lkp_ris, .lkp_partition_id,
        .lkp_width);

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic chk(string what, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic wrap_up();
        if (failures == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    // request stays up for back-to-back use; idle() drops it
    task automatic acc(logic w, logic [1:0] s, logic [11:0] o, logic [31:0] d, logic [31:0] e);
        req_valid = 1'b1;
        req_write = w;
        req_space = s;
        req_offset = o;
        req_wdata = d;
        exp_q.push_back(w ? zero : e);
        @(posedge clk_sys);
        #1;
    endtask : acc

    task automatic idle();
        req_valid = 1'b0;
        for (int i = 0; i < 8 && exp_q.size() != 0; i++) begin
            @(posedge clk_sys);
            #1;
        end
        if (exp_q.size() != 0) begin
            failures++;
            wrap_up();
        end
    endtask : idle

    // caps: bit0 partitioning .. bit6 realm, as the capability readback
    task automatic rst(logic [6:0] caps);
        idle();
        srst = 1'b1;
        {realm_management_support, has_id_narrowing, extended_id_flag, has_instance_selection,
            window_writable_flag, has_bandwidth_partitioning, partitioning_feature} = caps;
        repeat (20) @(posedge clk_sys);
        #1;
        srst = 1'b0;
    endtask : rst

    always @(posedge clk_sys) begin
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("spare answer", 32'h0000_0001, zero);
            end else begin
                chk("read data", exp_q.pop_front(), rsp_rdata);
            end
        end
    end

    initial begin
        seed = 32'h0001_6124;
        {req_valid, req_write, req_space, req_offset, req_wdata} = '0;
        {lkp_space, lkp_ris, lkp_partition_id} = {2'h3, 4'h2, 16'h0005};
        hw_window_width = 24'h00_0000;
        rst(7'h5F);
        acc(1'b0, 2'h0, OFF_CAPS, zero, 32'h0000_005F);
        acc(1'b0, 2'h0, OFF_PART_SEL, zero, zero);
        acc(1'b0, 2'h0, OFF_WINDOW_WIDTH, zero, zero);
        acc(1'b1, 2'h1, OFF_PART_SEL, 32'hFFFF_FFFF, zero);
        acc(1'b0, 2'h1, OFF_PART_SEL, zero, 32'h0F00_FFFF);
        // same selection everywhere, so only the space separates the stores
        for (int s = 0; s < 4; s++) begin
            wv[s] = rnd();
            acc(1'b1, 2'(s), OFF_PART_SEL, 32'h0200_0005, zero);
            acc(1'b1, 2'(s), OFF_WINDOW_WIDTH, wv[s], zero);
        end
        for (int s = 0; s < 4; s++) begin
            acc(1'b0, 2'(s), OFF_WINDOW_WIDTH, zero, wv[s] & 32'h00FF_FFFF);
        end
        acc(1'b1, 2'h0, OFF_PART_SEL, 32'h0100_0005, zero);
        acc(1'b0, 2'h0, OFF_WINDOW_WIDTH, zero, zero);
        acc(1'b1, 2'h0, OFF_PART_SEL, 32'h0200_0005, zero);
        acc(1'b0, 2'h0, OFF_WINDOW_WIDTH, zero, wv[0] & 32'h00FF_FFFF);
        idle();
        chk("lookup", wv[3] & 32'h00FF_FFFF, {8'h00, lkp_width});
        rst(7'h7F);
        acc(1'b1, 2'h1, OFF_PART_SEL, 32'h0000_0002, zero);
        acc(1'b1, 2'h1, OFF_WINDOW_WIDTH, 32'h0000_5A5A, zero);
        acc(1'b0, 2'h1, OFF_ERR_STATUS, zero, 32'(ERR_INTID_RANGE));
        acc(1'b1, 2'h1, OFF_ERR_STATUS, zero, zero);
        acc(1'b1, 2'h1, OFF_PART_SEL, 32'h0001_0002, zero);
        acc(1'b0, 2'h1, OFF_PART_SEL, zero, 32'h0001_0002);
        acc(1'b0, 2'h1, OFF_WINDOW_WIDTH, zero, zero);
        acc(1'b1, 2'h1, OFF_WINDOW_WIDTH, 32'h0012_3456, zero);
        acc(1'b0, 2'h1, OFF_WINDOW_WIDTH, zero, 32'h0012_3456);
        acc(1'b0, 2'h1, OFF_INTID_MAP, zero, zero);
        acc(1'b0, 2'h1, OFF_ERR_STATUS, zero, 32'(ERR_UNEXP_INTERNAL));
        // request id with flag clear reaches the mapping without a new error
        acc(1'b1, 2'h1, OFF_PART_SEL, 32'h0000_0002, zero);
        acc(1'b1, 2'h1, OFF_INTID_MAP, 32'h1234_BEEF, zero);
        acc(1'b0, 2'h1, OFF_INTID_MAP, zero, 32'h0000_BEEF);
        acc(1'b0, 2'h1, OFF_ERR_STATUS, zero, 32'(ERR_UNEXP_INTERNAL));
        lkp_space = 2'h0;
        rst(7'h0B);
        acc(1'b1, 2'h0, OFF_WINDOW_WIDTH, 32'h00AB_CDEF, zero);
        // hardware may move the width at any time
        for (int i = 0; i < 3; i++) begin
            hw_window_width = rnd() >> 8;
            acc(1'b0, 2'h0, OFF_WINDOW_WIDTH, zero, {8'h00, hw_window_width});
        end
        acc(1'b0, 2'h2, OFF_WINDOW_WIDTH, zero, zero);
        acc(1'b1, 2'h0, OFF_PART_SEL, 32'hFFFF_FFFF, zero);
        acc(1'b0, 2'h0, OFF_PART_SEL, zero, 32'h0000_FFFF);
        rst(7'h06);
        acc(1'b1, 2'h0, OFF_WINDOW_WIDTH, 32'h0000_1234, zero);
        acc(1'b0, 2'h0, OFF_WINDOW_WIDTH, zero, zero);
        rst(7'h57);
        acc(1'b1, 2'h1, OFF_PART_SEL, 32'h0100_0003, zero);
        acc(1'b1, 2'h1, OFF_WINDOW_WIDTH, 32'h0000_7788, zero);
        acc(1'b1, 2'h1, OFF_PART_SEL, 32'h0200_0003, zero);
        acc(1'b0, 2'h1, OFF_WINDOW_WIDTH, zero, 32'h0000_7788);
        idle();
        wrap_up();
    end
endmodule : partition_cfg_select_winwidth_tb_top
